// file: design/rsc_ctrl.v
`timescale 1ns/1ns
`include "rsc_map.vh"
module rsc_ctrl #(
  parameter RELOAD_CYC = `RSC_RELOAD_CYC,
  parameter SEC_CYC    = `RSC_SEC_CYC
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // event sources, one-cycle pulses; battery_low and intermediate_ts_flag are levels
  input  wire       tick_event,
  input  wire       watchdog_event,
  input  wire       timestamp_input_low,
  input  wire       alarm_event,
  input  wire       countdown_event,
  input  wire       switchover_event,
  input  wire       battery_low,
  input  wire       intermediate_ts_flag,
  // outputs to the rest of the clock
  output reg        irq,
  output reg  [2:0] power_management_field,
  output reg        switchover_timestamp,
  output reg  [2:0] clock_output_rate_field,
  output reg        square_wave_oe_n,
  output reg  [1:0] temp_period_field,
  output reg        temp_measure,
  output reg        reload_busy,
  output reg        reload_start
);
  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg        tick_event_flag;
  reg        watchdog_event_flag;
  reg        ground_timestamp_flag;
  reg        alarm_flag;
  reg        countdown_flag;
  reg        timestamp_irq_enable;
  reg        alarm_irq_enable;
  reg        countdown_irq_enable;
  reg        switchover_timestamp_enable;
  reg        switchover_flag;
  reg        battery_low_flag;
  reg        switchover_irq_enable;
  reg        battery_low_irq_enable;
  reg        calibration_refresh_bit;
  reg [31:0] reload_cnt;
  wire       measure_pulse;

  wire [7:0] event_image;
  wire [7:0] power_image;
  wire [7:0] square_wave_output_image;

  // one-hot register select codes
  localparam [2:0] SEL_NONE   = 3'h0;
  localparam [2:0] SEL_EVENT  = 3'h1;
  localparam [2:0] SEL_POWER  = 3'h2;
  localparam [2:0] SEL_SQUARE_WAVE_OUTPUT = 3'h4;

  // address decode shared by write strobes and read back
  function [2:0] reg_select;
    input [7:0] addr;
    begin
      case (addr)
        `RSC_ADDR_EVENT:  reg_select = SEL_EVENT;
        `RSC_ADDR_POWER:  reg_select = SEL_POWER;
        `RSC_ADDR_SQUARE_WAVE_OUTPUT: reg_select = SEL_SQUARE_WAVE_OUTPUT;
        default:          reg_select = SEL_NONE;
      endcase
    end
  endfunction

  wire [2:0] addr_sel  = reg_select(reg_addr);
  wire       wr_event  = reg_wr && addr_sel[0];
  wire       wr_power  = reg_wr && addr_sel[1];
  wire       wr_square_wave_output = reg_wr && addr_sel[2];

  // sticky flag: set wins over a software clear, writing one keeps it
  function next_flag;
    input cur;
    input set;
    input wr;
    input wbit;
    begin
      next_flag = set | (cur & ~(wr & ~wbit));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_event_flag       <= 1'b0;
      watchdog_event_flag   <= 1'b0;
      ground_timestamp_flag <= 1'b0;
      alarm_flag            <= 1'b0;
      countdown_flag        <= 1'b0;
      timestamp_irq_enable  <= 1'b0;
      alarm_irq_enable      <= 1'b0;
      countdown_irq_enable  <= 1'b0;
    end else begin
      tick_event_flag <= next_flag(tick_event_flag, tick_event, wr_event,
                                   reg_wdata[`RSC_BIT_TICK]);
      watchdog_event_flag <= watchdog_event_flag | watchdog_event;
      ground_timestamp_flag <= next_flag(ground_timestamp_flag, timestamp_input_low,
                                         wr_event, reg_wdata[`RSC_BIT_GTS]);
      alarm_flag <= next_flag(alarm_flag, alarm_event, wr_event,
                              reg_wdata[`RSC_BIT_ALARM]);
      countdown_flag <= next_flag(countdown_flag, countdown_event, wr_event,
                                  reg_wdata[`RSC_BIT_CDOWN]);
      if (wr_event) begin
        timestamp_irq_enable <= reg_wdata[`RSC_BIT_TIMESTAMP_IRQ_ENABLE];
        alarm_irq_enable     <= reg_wdata[`RSC_BIT_AIE];
        countdown_irq_enable <= reg_wdata[`RSC_BIT_CDIE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_management_field      <= 3'h0;
      switchover_timestamp_enable <= 1'b0;
      switchover_flag             <= 1'b0;
      battery_low_flag            <= 1'b0;
      switchover_irq_enable       <= 1'b0;
      battery_low_irq_enable      <= 1'b0;
      switchover_timestamp        <= 1'b0;
    end else begin
      if (wr_power) begin
        power_management_field      <= reg_wdata[`RSC_PWR_HI:`RSC_PWR_LO];
        switchover_timestamp_enable <= reg_wdata[`RSC_BIT_SWITCHOVER_TIMESTAMP_ENABLE];
        switchover_irq_enable       <= reg_wdata[`RSC_BIT_BIE];
        battery_low_irq_enable      <= reg_wdata[`RSC_BIT_BATTERY_LOW_IRQ_ENABLE];
      end
      switchover_flag <= next_flag(switchover_flag, switchover_event, wr_power,
                                   reg_wdata[`RSC_BIT_SWO]);
      battery_low_flag <= battery_low;
      switchover_timestamp <= switchover_event & switchover_timestamp_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output and compensation register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_period_field       <= `RSC_TCR_RESET;
      clock_output_rate_field <= `RSC_COF_RESET;
      square_wave_oe_n        <= 1'b0;
    end else begin
      if (wr_square_wave_output) begin
        temp_period_field       <= reg_wdata[`RSC_TCR_HI:`RSC_TCR_LO];
        clock_output_rate_field <= reg_wdata[`RSC_COF_HI:`RSC_COF_LO];
        square_wave_oe_n <= (reg_wdata[`RSC_COF_HI:`RSC_COF_LO] == `RSC_COF_HIZ);
      end
    end
  end

  // no reset: keeps its value across resets
  always @(posedge clk) begin
    if (wr_square_wave_output) begin
      calibration_refresh_bit <= reg_wdata[`RSC_BIT_CALIBRATION_REFRESH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration reload sequencer
  localparam [1:0] RLD_IDLE = 2'h0;
  localparam [1:0] RLD_BUSY = 2'h1;

  reg [1:0]  rld_state;
  reg [1:0]  next_rld_state;
  reg [31:0] next_reload_cnt;
  wire       refresh_rise;

  // only a stored, known zero followed by a written one starts a reload
  assign refresh_rise = wr_square_wave_output && reg_wdata[`RSC_BIT_CALIBRATION_REFRESH_BIT] &&
                        (calibration_refresh_bit == 1'b0);

  always @* begin
    next_rld_state  = rld_state;
    next_reload_cnt = reload_cnt;
    case (rld_state)
      RLD_IDLE: begin
        next_reload_cnt = 32'h0;
      end
      RLD_BUSY: begin
        if (reload_cnt >= RELOAD_CYC - 2) begin
          next_rld_state = RLD_IDLE;
        end else begin
          next_reload_cnt = reload_cnt + 32'h1;
        end
      end
      default: begin
        next_rld_state = RLD_IDLE;
      end
    endcase
    // a new rising refresh restarts the reload
    if (refresh_rise) begin
      next_rld_state  = RLD_BUSY;
      next_reload_cnt = 32'h0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rld_state    <= RLD_IDLE;
      reload_cnt   <= 32'h0;
      reload_busy  <= 1'b0;
      reload_start <= 1'b0;
    end else begin
      rld_state    <= next_rld_state;
      reload_cnt   <= next_reload_cnt;
      reload_busy  <= (next_rld_state == RLD_BUSY);
      reload_start <= refresh_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temperature scheduling
  rsc_period_timer #(
    .SEC_CYC (SEC_CYC)
  ) u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .period_sel (temp_period_field),
    .measure    (measure_pulse)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_measure <= 1'b0;
    end else begin
      temp_measure <= measure_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and read back
  // per-source enable gating; the tick flag has no enable of its own here
  wire [4:0] irq_flags;
  wire [4:0] irq_enables;
  wire [4:0] irq_terms;
  genvar     gi;

  assign irq_flags   = {battery_low_flag, switchover_flag, countdown_flag, alarm_flag,
                        ground_timestamp_flag | intermediate_ts_flag};
  assign irq_enables = {battery_low_irq_enable,
                        switchover_irq_enable,
                        countdown_irq_enable,
                        alarm_irq_enable,
                        timestamp_irq_enable};

  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_irq_term
      assign irq_terms[gi] = irq_flags[gi] & irq_enables[gi];
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (|irq_terms) | tick_event_flag;
    end
  end

  assign event_image  = {tick_event_flag, watchdog_event_flag, ground_timestamp_flag,
                         alarm_flag, countdown_flag, timestamp_irq_enable,
                         alarm_irq_enable, countdown_irq_enable};
  assign power_image  = {power_management_field, switchover_timestamp_enable,
                         switchover_flag, battery_low_flag, switchover_irq_enable,
                         battery_low_irq_enable};
  assign square_wave_output_image = {temp_period_field, calibration_refresh_bit, 2'h0,
                         clock_output_rate_field};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (addr_sel)
        SEL_EVENT:  reg_rdata <= event_image;
        SEL_POWER:  reg_rdata <= power_image;
        SEL_SQUARE_WAVE_OUTPUT: reg_rdata <= square_wave_output_image;
        default:    reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // rsc_ctrl

// file: design/rsc_period_timer.v
`timescale 1ns/1ns
`include "rsc_map.vh"
// temperature measurement scheduler: one tick right after reset, then periodic
module rsc_period_timer #(
  parameter SEC_CYC = `RSC_SEC_CYC
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // control
  input  wire [1:0] period_sel,
  // result
  output reg        measure
);
  reg [31:0] sub_cnt;
  reg [7:0]  sec_cnt;
  reg        started;
  wire [7:0] limit_s;

  assign limit_s = (period_sel == 2'h0) ? `RSC_PERIOD_4MIN :
                   (period_sel == 2'h1) ? `RSC_PERIOD_2MIN :
                   (period_sel == 2'h2) ? `RSC_PERIOD_1MIN : `RSC_PERIOD_30S;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt <= 32'h0;
      sec_cnt <= 8'h0;
      started <= 1'b0;
      measure <= 1'b0;
    end else begin
      measure <= 1'b0;
      if (!started) begin
        started <= 1'b1;
        measure <= 1'b1;
      end else if (sub_cnt >= SEC_CYC - 1) begin
        sub_cnt <= 32'h0;
        if (sec_cnt + 8'h1 >= limit_s) begin
          sec_cnt <= 8'h0;
          measure <= 1'b1;
        end else begin
          sec_cnt <= sec_cnt + 8'h1;
        end
      end else begin
        sub_cnt <= sub_cnt + 32'h1;
      end
    end
  end
endmodule // rsc_period_timer

// file: pkg/rsc_map.vh
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
// register offsets
`define RSC_ADDR_EVENT      8'h01
`define RSC_ADDR_POWER      8'h02
`define RSC_ADDR_SQUARE_WAVE_OUTPUT     8'h0F
// event register bits
`define RSC_BIT_TICK        7
`define RSC_BIT_WDOG        6
`define RSC_BIT_GTS         5
`define RSC_BIT_ALARM       4
`define RSC_BIT_CDOWN       3
`define RSC_BIT_TIMESTAMP_IRQ_ENABLE        2
`define RSC_BIT_AIE         1
`define RSC_BIT_CDIE        0
// power register bits
`define RSC_PWR_HI          7
`define RSC_PWR_LO          5
`define RSC_BIT_SWITCHOVER_TIMESTAMP_ENABLE        4
`define RSC_BIT_SWO         3
`define RSC_BIT_BLOW        2
`define RSC_BIT_BIE         1
`define RSC_BIT_BATTERY_LOW_IRQ_ENABLE        0
// clock output register bits
`define RSC_TCR_HI          7
`define RSC_TCR_LO          6
`define RSC_BIT_CALIBRATION_REFRESH_BIT        5
`define RSC_COF_HI          2
`define RSC_COF_LO          0
// reset values
`define RSC_EVENT_RESET     8'h00
`define RSC_POWER_RESET     8'h00
`define RSC_TCR_RESET       2'h0
`define RSC_COF_RESET       3'h0
`define RSC_COF_HIZ         3'h7
// timing
`define RSC_CLK_HZ          125000000
`define RSC_RELOAD_MS       100
`define RSC_RELOAD_CYC      ((`RSC_CLK_HZ / 1000) * `RSC_RELOAD_MS)
`define RSC_SEC_CYC         `RSC_CLK_HZ
// measurement periods in seconds
`define RSC_PERIOD_4MIN     8'hF0
`define RSC_PERIOD_2MIN     8'h78
`define RSC_PERIOD_1MIN     8'h3C
`define RSC_PERIOD_30S      8'h1E
`endif

// file: verif/rsc_ctrl_monitor.sv
`timescale 1ns/1ns
module rsc_ctrl_monitor #(
  parameter RELOAD_CYC = 20
) (
  // clock and reset
  input wire       clk,
  input wire       rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  // event inputs
  input wire       tick_event,
  input wire       switchover_event,
  input wire       battery_low,
  input wire       intermediate_ts_flag,
  // outputs
  input wire       irq,
  input wire [2:0] power_management_field,
  input wire       switchover_timestamp,
  input wire [2:0] clock_output_rate_field,
  input wire       square_wave_oe_n,
  input wire [1:0] temp_period_field,
  input wire       reload_busy,
  input wire       reload_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  integer busy_cnt;
  // length of the current reload
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt <= 0;
    else busy_cnt <= reload_busy ? busy_cnt + 1 : 0;
  end
  property p_oe_hiz; square_wave_oe_n == (clock_output_rate_field == 3'h7); endproperty
  a_oe_hiz: assert property (p_oe_hiz) else $error("output enable disagrees with rate");
  property p_reload_bound; busy_cnt <= RELOAD_CYC + 1; endproperty
  a_reload_bound: assert property (p_reload_bound) else $error("reload too long");
  property p_reload_cause;
    reload_start |-> $past(reg_wr) && $past(reg_addr) == 8'h0F && ($past(reg_wdata) & 8'h20) != 0;
  endproperty
  a_reload_cause: assert property (p_reload_cause) else $error("reload without write");
  property p_reload_busy; reload_start |-> reload_busy; endproperty
  a_reload_busy: assert property (p_reload_busy) else $error("start without busy");
  property p_tick_irq; tick_event |-> ##2 irq; endproperty
  a_tick_irq: assert property (p_tick_irq) else $error("tick raised no irq");
  property p_irq_fall;
    $fell(irq) |-> $past(reg_wr, 2) || $past(battery_low, 3) || $past(intermediate_ts_flag, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  property p_swo_ts; switchover_timestamp |-> $past(switchover_event); endproperty
  a_swo_ts: assert property (p_swo_ts) else $error("stray switchover timestamp");
  property p_pwr; !$stable(power_management_field) |-> $past(reg_wr) && $past(reg_addr) == 8'h02;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power field changed alone");
  property p_tcr; !$stable(temp_period_field) |-> $past(reg_wr) && $past(reg_addr) == 8'h0F;
  endproperty
  a_tcr: assert property (p_tcr) else $error("period field changed alone");
  c_reload: cover property (reload_start);
  c_irq_fall: cover property ($fell(irq));
  c_swo_ts: cover property (switchover_timestamp);
endmodule // rsc_ctrl_monitor
bind rsc_ctrl rsc_ctrl_monitor #(.RELOAD_CYC(RELOAD_CYC)) i_rsc_ctrl_monitor (.*);

// file: verif/rsc_ctrl_tb.sv
`timescale 1ns/1ns
module rsc_ctrl_tb;
  reg        clk, rst_n, battery_low, mid_ts;
  reg  [5:0] ev;
  reg  [7:0] d, a, e;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire       reg_wr, reg_rd, irq, swo_ts, oe_n, measure, busy, start;
  wire [2:0] pwr, rate;
  wire [1:0] tcr;
  integer    n_errors, compares, i, n;
  always #4 clk = ~clk;
  rsc_ctrl #(.RELOAD_CYC(20), .SEC_CYC(10)) i_rsc_ctrl (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tick_event(ev[4]), .watchdog_event(ev[5]),
    .timestamp_input_low(ev[2]), .alarm_event(ev[0]), .countdown_event(ev[1]),
    .switchover_event(ev[3]), .battery_low(battery_low), .intermediate_ts_flag(mid_ts),
    .irq(irq), .power_management_field(pwr), .switchover_timestamp(swo_ts),
    .clock_output_rate_field(rate), .square_wave_oe_n(oe_n), .temp_period_field(tcr),
    .temp_measure(measure), .reload_busy(busy), .reload_start(start));
  rsc_host i_rsc_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task pulse(input integer k);
    begin
      @(negedge clk);
      ev[k] = 1'h1;
      @(negedge clk);
      ev[k] = 1'h0;
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'h0;
      repeat (2) @(negedge clk);
      rst_n = 1'h1;
    end
  endtask
  task results;
    begin
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    clk = 1'h0;
    ev = 6'h00;
    battery_low = 1'h0;
    mid_ts = 1'h0;
    n_errors = 0;
    compares = 0;
    do_reset;
    i_rsc_host.rd(8'h01, d);
    chk(d, 8'h00);
    i_rsc_host.rd(8'h02, d);
    chk(d, 8'h00);
    i_rsc_host.rd(8'h0F, d);
    chk(d & 8'hDF, 8'h00);
    chk({rate, oe_n}, 8'h00);
    i_rsc_host.rd(8'h05, d);
    chk(d, 8'h00);
    i_rsc_host.refresh(8'h00);
    chk({busy, start}, 8'h03);
    n = 0;
    while (busy && n < 100) begin
      @(negedge clk);
      n = n + 1;
    end
    chk(n <= 20, 1'h1);
    $display("test reload done");
    battery_low = 1'h1;
    for (i = 0; i < 6; i = i + 1) pulse(i);
    i_rsc_host.rd(8'h01, d);
    chk(d, 8'hF8);
    i_rsc_host.rd(8'h02, d);
    chk(d, 8'h0C);
    i_rsc_host.wr(8'h01, 8'hF8);
    i_rsc_host.rd(8'h01, d);
    chk(d, 8'hF8);
    i_rsc_host.wr(8'h01, 8'h00);
    i_rsc_host.rd(8'h01, d);
    chk(d, 8'h40);
    i_rsc_host.wr(8'h02, 8'h00);
    i_rsc_host.rd(8'h02, d);
    chk(d, 8'h04);
    battery_low = 1'h0;
    i_rsc_host.rd(8'h02, d);
    chk(d, 8'h00);
    do_reset;
    repeat (2) @(negedge clk);
    chk(measure, 1'h1);
    i_rsc_host.rd(8'h01, d);
    chk(d, 8'h00);
    i_rsc_host.rd(8'h0F, d);
    chk(d & 8'h20, 8'h20);
    $display("test flags done");
    for (i = 0; i < 4; i = i + 1) begin
      a = (i == 3) ? 8'h02 : 8'h01;
      e = (i == 0 || i == 3) ? 8'h02 : (i == 1) ? 8'h01 : 8'h04;
      i_rsc_host.wr(a, e);
      pulse(i);
      @(negedge clk);
      chk(irq, 1'h1);
      i_rsc_host.wr(a, e);
      @(negedge clk);
      chk(irq, 1'h0);
      i_rsc_host.wr(a, 8'h00);
      pulse(i);
      @(negedge clk);
      chk(irq, 1'h0);
      i_rsc_host.wr(a, 8'h00);
    end
    i_rsc_host.wr(8'h02, 8'h01);
    battery_low = 1'h1;
    repeat (2) @(negedge clk);
    chk(irq, 1'h1);
    battery_low = 1'h0;
    repeat (2) @(negedge clk);
    chk(irq, 1'h0);
    i_rsc_host.wr(8'h01, 8'h04);
    mid_ts = 1'h1;
    repeat (2) @(negedge clk);
    chk(irq, 1'h1);
    mid_ts = 1'h0;
    pulse(4);
    @(negedge clk);
    chk(irq, 1'h1);
    $display("test irq done");
    i_rsc_host.wr(8'h02, 8'hF0);
    chk(pwr, 3'h7);
    pulse(3);
    chk(swo_ts, 1'h1);
    i_rsc_host.wr(8'h02, 8'h00);
    pulse(3);
    chk(swo_ts, 1'h0);
    for (i = 0; i < 8; i = i + 1) begin
      i_rsc_host.wr(8'h0F, {i[1:0], 3'h7, i[2:0]});
      i_rsc_host.rd(8'h0F, d);
      chk(d, {i[1:0], 3'h4, i[2:0]});
      chk({tcr, oe_n, rate}, {i[1:0], i == 7, i[2:0]});
    end
    $display("test output control done");
    n = 0;
    while (!measure && n < 3000) begin
      @(negedge clk);
      n = n + 1;
    end
    @(negedge clk);
    n = 0;
    while (!measure && n < 3000) begin
      @(negedge clk);
      n = n + 1;
    end
    chk(n == 299, 1'h1);
    $display("test measurement done");
    results;
  end
endmodule // rsc_ctrl_tb

// file: verif/rsc_host.sv
`timescale 1ns/1ns
module rsc_host (
  // clock
  input  wire       clk,
  // register port
  input  wire [7:0] reg_rdata,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge clk);
      reg_wr = 1'h0;
      reg_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge clk);
      reg_rd = 1'h0;
      d = reg_rdata;
    end
  endtask
  // reload needs a known zero before the one
  task refresh(input [7:0] base);
    begin
      wr(8'h0F, base & 8'hDF);
      wr(8'h0F, base | 8'h20);
    end
  endtask
endmodule // rsc_host
